//--- pkg/pmbmr_consts.svh
// constants for the margin command register bank
// Function
// - margin upper code is held in bits 11..2; other bits ignored on write.
// - margin lower code is held in bits 11..2; other bits ignored on write.
// - 8-bit variant uses upper eight bits of the field; 10-bit uses all ten.
// - margin upper at 25h, margin lower at 26h, both reset to zero.
// - command byte 00h off, 80h on, A4h go to margin upper code.
// - command byte 94h drives output toward margin lower code.
// - operation register is read/write, resets 0000h, low byte unused.
// - fault flag bit 9 at 78h sets on timeout, bad clock count, early read.
// - writing one to bit 9 clears the fault flag; reads zero without fault.
// - status register resets 0000h, all other bits read zero.
// - register 98h always reads 2200h, revision 22h in upper byte.
// - margin request bits clear themselves once output reaches the margin code.
// - moves between margin and nominal codes step at the slew rate.
`ifndef PMBMR_CONSTS_SVH
`define PMBMR_CONSTS_SVH
`define PMBMR_ADDR_OPERATION  8'h01
`define PMBMR_ADDR_MARGIN_HI  8'h25
`define PMBMR_ADDR_MARGIN_LO  8'h26
`define PMBMR_ADDR_STATUS     8'h78
`define PMBMR_ADDR_REVISION   8'h98
`define PMBMR_CODE_MSB        11
`define PMBMR_CODE_LSB        2
`define PMBMR_CODE8_LSB       4
`define PMBMR_CMD_MSB         15
`define PMBMR_CMD_LSB         8
`define PMBMR_FAULT_BIT       9
`define PMBMR_CMD_OFF         8'h00
`define PMBMR_CMD_ON          8'h80
`define PMBMR_CMD_MARGIN_HI   8'ha4
`define PMBMR_CMD_MARGIN_LO   8'h94
`define PMBMR_REVISION_VALUE  16'h2200
`define PMBMR_ZERO16          16'h0000
`define PMBMR_ZERO10          10'h000
`define PMBMR_ZERO8           8'h00
`define PMBMR_STEP10          10'h001
`define PMBMR_STEP8           10'h004
`define PMBMR_SLEW_DIV        8'h63
`endif

//--- pkg/pmbmr_pkg.sv
// types of the margin command register bank
`default_nettype none
package pmbmr_pkg;
  typedef enum logic [1:0] {
    PMBMR_OUT_OFF,
    PMBMR_OUT_ON,
    PMBMR_OUT_MARGIN_HI,
    PMBMR_OUT_MARGIN_LO
  } pmbmr_mode_type;

  typedef struct packed {
    logic [7:0]     cmd;
    logic [9:0]     margin_hi;
    logic [9:0]     margin_lo;
    logic           fault;
    pmbmr_mode_type mode;
    logic           hi_req;
    logic           lo_req;
    logic [15:0]    rdata;
    logic           rvalid;
    logic           seq_req;
    logic [9:0]     code;
    logic           out_en;
  } pmbmr_top_state_type;

  typedef struct packed {
    logic [7:0] div;
    logic [9:0] code;
  } pmbmr_slew_state_type;
endpackage : pmbmr_pkg
`default_nettype wire

//--- pkg/pmbmr_seq_if.sv
// link between register bank and output sequencer
`timescale 1ns/1ps
`default_nettype none
interface pmbmr_seq_if;
  logic       req;
  logic [9:0] target;
  logic       coarse;
  logic [9:0] code;
  logic       arrived;
  modport ctrl (output req, output target, output coarse, input code, input arrived);
  modport seq  (input req, input target, input coarse, output code, output arrived);
endinterface : pmbmr_seq_if
`default_nettype wire

//--- hdl/pmbmr_slew.sv
// output sequencer stepping the code toward its target at the slew rate
`timescale 1ns/1ps
`default_nettype none
`include "pmbmr_consts.svh"
module pmbmr_slew (
  input  wire logic   clk_sys,
  input  wire logic   reset,
  pmbmr_seq_if.seq    seq
);
  pmbmr_pkg::pmbmr_slew_state_type s_q;
  pmbmr_pkg::pmbmr_slew_state_type s_d;
  logic [9:0] step;
  logic       tick;

  always_comb begin
    s_d  = s_q;
    step = seq.coarse ? `PMBMR_STEP8 : `PMBMR_STEP10;
    // request restarts the divider so the first step lands at once
    tick = seq.req || (s_q.div == `PMBMR_ZERO8);
    if (tick) begin
      s_d.div = `PMBMR_SLEW_DIV;
    end else begin
      s_d.div = s_q.div - 8'h01;
    end
    if (tick) begin
      if (s_q.code < seq.target) begin
        if (seq.target - s_q.code > step) begin
          s_d.code = s_q.code + step;
        end else begin
          s_d.code = seq.target;
        end
      end else if (s_q.code > seq.target) begin
        if (s_q.code - seq.target > step) begin
          s_d.code = s_q.code - step;
        end else begin
          s_d.code = seq.target;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign seq.code    = s_q.code;
  assign seq.arrived = (s_q.code == seq.target);
endmodule : pmbmr_slew
`default_nettype wire

//--- hdl/pmbmr_top.sv
// margin command register bank with its output sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pmbmr_consts.svh"
module pmbmr_top #(
  parameter bit EIGHT_BIT = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rd_valid,
  input  wire logic        fault_timeout,
  input  wire logic        fault_clock_count,
  input  wire logic        fault_read_early,
  input  wire logic        trig_margin_hi,
  input  wire logic        trig_margin_lo,
  input  wire logic [9:0]  nominal_code,
  output logic             margin_hi_pending,
  output logic             margin_lo_pending,
  output logic      [9:0]  dac_code,
  output logic             output_on
);
  pmbmr_pkg::pmbmr_top_state_type s_q;
  pmbmr_pkg::pmbmr_top_state_type s_d;
  pmbmr_seq_if seq ();

  logic       wr_op;
  logic       wr_hi;
  logic       wr_lo;
  logic       wr_st;
  logic [9:0] wcode;
  logic [7:0] wcmd;
  logic       cmd_known;
  logic       go_hi;
  logic       go_lo;

  pmbmr_slew u_slew (
    .clk_sys (clk_sys),
    .reset   (reset),
    .seq     (seq)
  );

  always_comb begin
    wr_op = reg_wr_en && (reg_addr == `PMBMR_ADDR_OPERATION);
    wr_hi = reg_wr_en && (reg_addr == `PMBMR_ADDR_MARGIN_HI);
    wr_lo = reg_wr_en && (reg_addr == `PMBMR_ADDR_MARGIN_LO);
    wr_st = reg_wr_en && (reg_addr == `PMBMR_ADDR_STATUS);
    wcmd  = reg_wdata[`PMBMR_CMD_MSB:`PMBMR_CMD_LSB];
    // 8-bit parts drop the two lowest code bits, keeping msb alignment
    if (EIGHT_BIT) begin
      wcode = {reg_wdata[`PMBMR_CODE_MSB:`PMBMR_CODE8_LSB], 2'b00};
    end else begin
      wcode = reg_wdata[`PMBMR_CODE_MSB:`PMBMR_CODE_LSB];
    end
    cmd_known = (wcmd == `PMBMR_CMD_OFF) || (wcmd == `PMBMR_CMD_ON) ||
                (wcmd == `PMBMR_CMD_MARGIN_HI) || (wcmd == `PMBMR_CMD_MARGIN_LO);
    go_hi = trig_margin_hi || (wr_op && (wcmd == `PMBMR_CMD_MARGIN_HI));
    go_lo = trig_margin_lo || (wr_op && (wcmd == `PMBMR_CMD_MARGIN_LO));
  end

  always_comb begin
    s_d = s_q;
    s_d.seq_req = 1'b0;
    s_d.rvalid  = 1'b0;
    if (wr_hi) begin
      s_d.margin_hi = wcode;
    end
    if (wr_lo) begin
      s_d.margin_lo = wcode;
    end
    if (wr_op) begin
      // command byte stays readable even when it has no meaning
      s_d.cmd = wcmd;
      if (cmd_known) begin
        s_d.seq_req = 1'b1;
        unique case (wcmd)
          `PMBMR_CMD_OFF: begin
            s_d.mode = pmbmr_pkg::PMBMR_OUT_OFF;
          end
          `PMBMR_CMD_ON: begin
            s_d.mode = pmbmr_pkg::PMBMR_OUT_ON;
          end
          `PMBMR_CMD_MARGIN_HI: begin
            s_d.mode = pmbmr_pkg::PMBMR_OUT_MARGIN_HI;
          end
          `PMBMR_CMD_MARGIN_LO: begin
            s_d.mode = pmbmr_pkg::PMBMR_OUT_MARGIN_LO;
          end
          default: begin
            s_d.mode = s_q.mode;
          end
        endcase
      end
      // unknown bytes fall through with the mode untouched
    end
    if (trig_margin_hi) begin
      s_d.mode    = pmbmr_pkg::PMBMR_OUT_MARGIN_HI;
      s_d.seq_req = 1'b1;
    end else if (trig_margin_lo) begin
      s_d.mode    = pmbmr_pkg::PMBMR_OUT_MARGIN_LO;
      s_d.seq_req = 1'b1;
    end
    // request drops on arrival; a fresh request in the same cycle wins
    if (go_hi) begin
      s_d.hi_req = 1'b1;
      s_d.lo_req = 1'b0;
    end else if (s_q.hi_req && seq.arrived &&
                 (s_q.mode == pmbmr_pkg::PMBMR_OUT_MARGIN_HI)) begin
      s_d.hi_req = 1'b0;
    end
    if (go_lo && !go_hi) begin
      s_d.lo_req = 1'b1;
      s_d.hi_req = 1'b0;
    end else if (s_q.lo_req && seq.arrived &&
                 (s_q.mode == pmbmr_pkg::PMBMR_OUT_MARGIN_LO)) begin
      s_d.lo_req = 1'b0;
    end
    if (s_q.mode != pmbmr_pkg::PMBMR_OUT_MARGIN_HI && !go_hi) begin
      s_d.hi_req = 1'b0;
    end
    if (s_q.mode != pmbmr_pkg::PMBMR_OUT_MARGIN_LO && !go_lo) begin
      s_d.lo_req = 1'b0;
    end
    // a new fault beats a clear in the same cycle
    if (wr_st && reg_wdata[`PMBMR_FAULT_BIT]) begin
      s_d.fault = 1'b0;
    end
    if (fault_timeout || fault_clock_count || fault_read_early) begin
      s_d.fault = 1'b1;
    end
    if (reg_rd_en) begin
      s_d.rvalid = 1'b1;
      unique case (reg_addr)
        `PMBMR_ADDR_OPERATION: begin
          s_d.rdata = {s_q.cmd, `PMBMR_ZERO8};
        end
        `PMBMR_ADDR_STATUS: begin
          s_d.rdata = `PMBMR_ZERO16;
          s_d.rdata[`PMBMR_FAULT_BIT] = s_q.fault;
        end
        `PMBMR_ADDR_REVISION: begin
          s_d.rdata = `PMBMR_REVISION_VALUE;
        end
        default: begin
          // margin codes are write-only and read back as zero
          s_d.rdata = `PMBMR_ZERO16;
        end
      endcase
    end
    s_d.code   = seq.code;
    s_d.out_en = (s_q.mode != pmbmr_pkg::PMBMR_OUT_OFF);
  end

  always_comb begin
    seq.req    = s_q.seq_req;
    seq.coarse = EIGHT_BIT;
    // off holds the last code so turning on resumes from there
    unique case (s_q.mode)
      pmbmr_pkg::PMBMR_OUT_OFF: begin
        seq.target = seq.code;
      end
      pmbmr_pkg::PMBMR_OUT_ON: begin
        seq.target = nominal_code;
      end
      pmbmr_pkg::PMBMR_OUT_MARGIN_HI: begin
        seq.target = s_q.margin_hi;
      end
      pmbmr_pkg::PMBMR_OUT_MARGIN_LO: begin
        seq.target = s_q.margin_lo;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_q           <= '0;
      s_q.mode      <= pmbmr_pkg::PMBMR_OUT_OFF;
      s_q.margin_hi <= `PMBMR_ZERO10;
      s_q.margin_lo <= `PMBMR_ZERO10;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata         = s_q.rdata;
  assign reg_rd_valid      = s_q.rvalid;
  assign margin_hi_pending = s_q.hi_req;
  assign margin_lo_pending = s_q.lo_req;
  assign dac_code          = s_q.code;
  assign output_on         = s_q.out_en;
endmodule : pmbmr_top
`default_nettype wire

//--- verif/pmbmr_props.sv
// assertion checker for the margin command register bank
`timescale 1ns/1ps
`default_nettype none
module pmbmr_props #(
  parameter bit EIGHT_BIT = 1'b0
) (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        reg_wr_en,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rd_valid,
  input wire logic        fault_timeout,
  input wire logic        fault_clock_count,
  input wire logic        fault_read_early,
  input wire logic        margin_hi_pending,
  input wire logic        margin_lo_pending,
  input wire logic [9:0]  dac_code,
  input wire logic        output_on
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic       wr_op;
  logic       any_flt;
  logic [9:0] step;
  assign wr_op   = reg_wr_en && reg_addr == 8'h01;
  assign any_flt = fault_timeout || fault_clock_count || fault_read_early;
  // a step is one code in the 10-bit variant, four in the 8-bit one
  assign step    = EIGHT_BIT ? 10'h004 : 10'h001;
  a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read not answered");
  a_rd_quiet: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("read valid without a read");
  a_fault_clears: assert property ((reg_wr_en && reg_addr == 8'h78 && reg_wdata[9] && !any_flt)
    ##1 !any_flt ##1 (reg_rd_en && reg_addr == 8'h78) |=> !reg_rdata[9])
    else $error("fault flag not cleared");
  a_revision_read: assert property (reg_rd_en && reg_addr == 8'h98 |=> reg_rdata == 16'h2200)
    else $error("revision value wrong");
  a_status_unused: assert property (reg_rd_en && reg_addr == 8'h78
    |=> reg_rdata[15:10] == 6'h00 && reg_rdata[8:0] == 9'h000)
    else $error("status unused bits set");
  a_margin_wo: assert property (reg_rd_en && (reg_addr == 8'h25 || reg_addr == 8'h26)
    |=> reg_rdata == 16'h0000)
    else $error("margin register not write only");
  a_fault_sets: assert property (any_flt ##2 (reg_rd_en && reg_addr == 8'h78) |=> reg_rdata[9])
    else $error("fault flag not set");
  a_cmd_on: assert property (wr_op && reg_wdata[15:8] == 8'h80 |-> ##2 output_on)
    else $error("on command ignored");
  a_cmd_off: assert property (wr_op && reg_wdata[15:8] == 8'h00 |-> ##2 !output_on)
    else $error("off command ignored");
  a_hi_request: assert property (wr_op && reg_wdata[15:8] == 8'ha4 |=> margin_hi_pending)
    else $error("margin high not requested");
  a_lo_request: assert property (wr_op && reg_wdata[15:8] == 8'h94 |=> margin_lo_pending)
    else $error("margin low not requested");
  a_slew_step: assert property ($changed(dac_code) |-> 10'(dac_code - $past(dac_code)) == step
    || 10'($past(dac_code) - dac_code) == step)
    else $error("code jumped more than one step");
endmodule : pmbmr_props
bind pmbmr_top pmbmr_props #(.EIGHT_BIT(EIGHT_BIT)) i_pmbmr_props (.clk_sys, .reset, .reg_wr_en,
  .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid, .fault_timeout, .fault_clock_count,
  .fault_read_early, .margin_hi_pending, .margin_lo_pending, .dac_code, .output_on);
`default_nettype wire

//--- verif/pmbmr_host.sv
// host controller model issuing register commands
`timescale 1ns/1ps
`default_nettype none
module pmbmr_host (
  input  wire logic        clk_sys,
  output var  logic        reg_wr_en,
  output var  logic        reg_rd_en,
  output var  logic [7:0]  reg_addr,
  output var  logic [15:0] reg_wdata,
  input  wire logic        reg_rd_valid,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
  end
  // idle lines show the inverse so a stale value cannot pass as valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [16:0] r);
    @(negedge clk_sys);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    r = {reg_rd_valid, reg_rdata};
  endtask : rd
endmodule : pmbmr_host
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the margin command register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys, reset, trig_margin_hi, trig_margin_lo, reg_wr_en, reg_rd_en;
  logic        reg_rd_valid, margin_hi_pending, margin_lo_pending, output_on;
  logic [2:0]  flt;
  logic [7:0]  reg_addr;
  logic [9:0]  nominal_code, dac_code;
  logic [15:0] reg_wdata, reg_rdata;
  logic [16:0] r;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  pmbmr_host i_pmbmr_host (.clk_sys, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rd_valid,
    .reg_rdata);
  pmbmr_top i_pmbmr_top (.clk_sys, .reset, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rd_valid, .fault_timeout(flt[0]), .fault_clock_count(flt[1]),
    .fault_read_early(flt[2]), .trig_margin_hi, .trig_margin_lo, .nominal_code,
    .margin_hi_pending, .margin_lo_pending, .dac_code, .output_on);
  task automatic chk(input string n, input logic [16:0] s, input logic [16:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    i_pmbmr_host.rd(a, r);
    chk("read", r, {1'b1, e});
  endtask : rchk
  // bounded wait: a slew step takes a hundred clocks
  task automatic wait_code(input logic [9:0] e);
    int n;
    n = 0;
    while (dac_code !== e && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    chk("code", dac_code, e);
  endtask : wait_code
  task automatic t_regs;
    rchk(8'h01, 16'h0000);
    rchk(8'h78, 16'h0000);
    rchk(8'h25, 16'h0000);
    rchk(8'h40, 16'h0000);
    i_pmbmr_host.wr(8'h98, 16'h0000);
    rchk(8'h98, 16'h2200);
    i_pmbmr_host.wr(8'h01, 16'h12ff);
    rchk(8'h01, 16'h1200);
    chk("on", output_on, 1'b0);
  endtask : t_regs
  task automatic t_fault;
    for (int i = 0; i < 3; i++) begin
      flt[i] = 1'b1;
      @(negedge clk_sys);
      flt = 3'h0;
      rchk(8'h78, 16'h0200);
      i_pmbmr_host.wr(8'h78, 16'h0200);
      rchk(8'h78, 16'h0000);
    end
    // fault and clear in one cycle: the fault must survive
    flt[0] = 1'b1;
    i_pmbmr_host.wr(8'h78, 16'h0200);
    flt = 3'h0;
    rchk(8'h78, 16'h0200);
    i_pmbmr_host.wr(8'h78, 16'h0200);
    rchk(8'h78, 16'h0000);
  endtask : t_fault
  task automatic t_margin;
    i_pmbmr_host.wr(8'h25, 16'hf00f);
    i_pmbmr_host.wr(8'h26, 16'hf00b);
    i_pmbmr_host.wr(8'h01, 16'ha400);
    repeat (3) @(negedge clk_sys);
    chk("first step", dac_code, 10'h001);
    chk("on", output_on, 1'b1);
    wait_code(10'h003);
    repeat (2) @(negedge clk_sys);
    chk("hi pending", margin_hi_pending, 1'b0);
    i_pmbmr_host.wr(8'h01, 16'h9400);
    wait_code(10'h002);
    i_pmbmr_host.wr(8'h01, 16'h8000);
    wait_code(10'h005);
    i_pmbmr_host.wr(8'h01, 16'h0000);
    i_pmbmr_host.wr(8'h01, 16'h5500);
    repeat (3) @(negedge clk_sys);
    chk("off", {output_on, dac_code}, {1'b0, 10'h005});
    trig_margin_hi = 1'b1;
    @(negedge clk_sys);
    trig_margin_hi = 1'b0;
    chk("hi pending", margin_hi_pending, 1'b1);
    wait_code(10'h003);
    repeat (2) @(negedge clk_sys);
    chk("hi pending", margin_hi_pending, 1'b0);
    trig_margin_lo = 1'b1;
    @(negedge clk_sys);
    trig_margin_lo = 1'b0;
    chk("lo pending", margin_lo_pending, 1'b1);
    wait_code(10'h002);
    repeat (2) @(negedge clk_sys);
    chk("lo pending", margin_lo_pending, 1'b0);
  endtask : t_margin
  // mid-run reset: margin upper code must be back at zero afterwards
  task automatic t_reset;
    flt[1] = 1'b1;
    @(negedge clk_sys);
    flt = 3'h0;
    reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    chk("reset outputs", {output_on, margin_hi_pending, margin_lo_pending, dac_code},
      13'h0000);
    rchk(8'h01, 16'h0000);
    rchk(8'h78, 16'h0000);
    i_pmbmr_host.wr(8'h01, 16'ha400);
    repeat (3) @(negedge clk_sys);
    chk("margin after reset", {output_on, dac_code}, {1'b1, 10'h000});
  endtask : t_reset
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    reset = 1'b1;
    flt = 3'h0;
    trig_margin_hi = 1'b0;
    trig_margin_lo = 1'b0;
    nominal_code = 10'h005;
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    t_regs;
    t_fault;
    t_margin;
    t_reset;
    final_report;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      final_report;
    end
  end
endmodule : tb_top
`default_nettype wire
